// >>> fts_burst.sv
// Shared constants and types plus the burst address sequencer.
package fts_pkg;
	// ----------------------------------------------------------------
	// Geometry and reset values
	// ----------------------------------------------------------------
	localparam int          ADDR_W     = 19;
	localparam int          DATA_W     = 16;
	localparam int          LANES      = 2;
	localparam int          LANE_W     = 8;
	localparam int          DEPTH      = 524288;
	localparam logic [18:0] ADDR_RST   = 19'h00000;
	localparam logic [1:0]  CNT_RST    = 2'h0;
	localparam logic [1:0]  CNT_STEP   = 2'h1;
	localparam logic [2:0]  SYNC_RST   = 3'h0;
	localparam logic        ORDER_RST  = 1'b1;
	localparam logic [17:0] WORD_RST   = 18'h00000;

	typedef struct packed {
		logic [18:0] addr;
		logic        processor_addr_strobe_n;
		logic        controller_addr_strobe_n;
		logic        chip_select_a_n;
		logic        chip_select_b;
		logic        burst_step_n;
		logic        global_write_n;
		logic        byte_write_gate_n;
		logic [1:0]  byte_lane_select_n;
	} fts_req_t;

	typedef struct packed {
		logic [1:0]  parity_io;
		logic [15:0] data;
	} fts_word_t;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_READ  = 2'b01,
		ST_WRITE = 2'b10
	} fts_state_t;
endpackage

`timescale 1ns/10ps

module fts_burst_seq (
	input  wire logic       interleaved,
	input  wire logic [1:0] start,
	input  wire logic [1:0] count,
	output logic      [1:0] low_addr
);
	// Both orders wrap within the aligned group of four.
	always_comb begin
		if (interleaved) begin
			low_addr = start ^ count;
		end else begin
			low_addr = 2'(start + count);
		end
	end
endmodule

// >>> fts_sram_port.sv
// Synchronous flow-through SRAM port with burst counter and memory array.
// ------------------------------------------------------------------------
// Functional notes
// - Controller strobe low captures the address.
// - Any capture loads address bits 1:0 into counter.
// - Processor strobe wins over controller strobe.
// - Sleep input high idles device, keeps contents.
// - Sleep input held low for normal operation.
// - Input data taken at the rising edge.
// - Read data follows previous edge address, unpipelined.
// - Output enable low drives, high floats lines.
// - Float during writes, deselect and sleep.
// - Parity lanes follow their byte-lane write select.
// - Order input low linear, high interleaved.
// - Order input is a static strap.
// - Processor strobe captures when chip selected.
// - Global write writes every byte lane.
// - Step input low advances the burst counter.
// ------------------------------------------------------------------------
`timescale 1ns/10ps

module fts_sram_port (
	input  wire logic              CLOCK,
	input  wire logic              RST_N,
	input  wire logic              CLK_EN,
	input  wire fts_pkg::fts_req_t BUS_REQ,
	input  wire logic              BURST_ORDER,
	input  wire logic              SLEEP_REQUEST,
	input  wire logic              OUTPUT_ENABLE_N,
	input  wire fts_pkg::fts_word_t DQ_IN,
	output fts_pkg::fts_word_t     DQ_OUT,
	output logic                   DQ_OE,
	output logic                   SLEEPING
);
	import fts_pkg::*;

	// ----------------------------------------------------------------
	// Pin synchronisers and strap capture
	// ----------------------------------------------------------------
	logic [2:0] sync1_r, sync1_nxt;
	logic [2:0] sync2_r, sync2_nxt;
	logic       order_r, order_nxt;
	logic       sleep_s;
	logic       oe_n_s;

	always_comb begin
		sync1_nxt = {BURST_ORDER, OUTPUT_ENABLE_N, SLEEP_REQUEST};
		sync2_nxt = sync1_r;
		order_nxt = order_r;
		if (!RST_N) begin
			// The strap keeps moving through both stages so that reset
			// latches the settled pin level, not a cleared stage.
			sync1_nxt = {BURST_ORDER, SYNC_RST[1:0]};
			sync2_nxt = {sync1_r[2], SYNC_RST[1:0]};
			order_nxt = sync2_r[2];
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!RST_N || CLK_EN) begin
			sync1_r <= sync1_nxt;
			sync2_r <= sync2_nxt;
			order_r <= order_nxt;
		end
	end

	// An unconnected sleep pin reads low through the pad pull-down.
	assign sleep_s  = sync2_r[0];
	assign oe_n_s   = sync2_r[1];
	assign SLEEPING = sleep_s;

	// ----------------------------------------------------------------
	// Address capture, burst counter and cycle state
	// ----------------------------------------------------------------
	fts_state_t  state_r, state_nxt;
	logic [18:0] addr_r, addr_nxt;
	logic [18:0] eff_addr_r, eff_addr_nxt;
	logic [1:0]  start_r, start_nxt;
	logic [1:0]  cnt_r, cnt_nxt;
	logic [1:0]  low_nxt;
	logic        processor_addr_strobe_n_take;
	logic        controller_addr_strobe_n_take;
	logic        sel_now;
	logic        wr_now;
	logic        do_write;
	logic [1:0]  lane_we;

	// Processor strobe is ignored unless chip select A is low.
	assign processor_addr_strobe_n_take = !BUS_REQ.processor_addr_strobe_n
		&& !BUS_REQ.chip_select_a_n;
	assign controller_addr_strobe_n_take = !processor_addr_strobe_n_take
		&& !BUS_REQ.controller_addr_strobe_n;
	assign sel_now = !BUS_REQ.chip_select_a_n && BUS_REQ.chip_select_b;
	// Global write overrides the gate and lane selects.
	assign lane_we = BUS_REQ.global_write_n
		? ({2{!BUS_REQ.byte_write_gate_n}}
		& ~BUS_REQ.byte_lane_select_n)
		: 2'h3;
	assign wr_now = |lane_we;

	always_comb begin
		state_nxt = state_r;
		addr_nxt  = addr_r;
		start_nxt = start_r;
		cnt_nxt   = cnt_r;
		do_write  = 1'b0;
		if (!RST_N) begin
			state_nxt = ST_IDLE;
			addr_nxt  = ADDR_RST;
			start_nxt = CNT_RST;
			cnt_nxt   = CNT_RST;
		end else if (sleep_s) begin
			// Sleep deselects; the array is left untouched.
			state_nxt = ST_IDLE;
		end else if (processor_addr_strobe_n_take || controller_addr_strobe_n_take) begin
			addr_nxt  = BUS_REQ.addr;
			start_nxt = BUS_REQ.addr[1:0];
			cnt_nxt   = CNT_RST;
			if (!sel_now) begin
				state_nxt = ST_IDLE;
			end else if (controller_addr_strobe_n_take && wr_now) begin
				state_nxt = ST_WRITE;
				do_write  = 1'b1;
			end else begin
				// A processor strobe always opens with a read.
				state_nxt = ST_READ;
			end
		end else if (state_r != ST_IDLE) begin
			if (!BUS_REQ.burst_step_n) begin
				cnt_nxt = 2'(cnt_r + CNT_STEP);
			end
			if (wr_now) begin
				state_nxt = ST_WRITE;
				do_write  = 1'b1;
			end else begin
				state_nxt = ST_READ;
			end
		end
	end

	fts_burst_seq u_seq (
		.interleaved (order_r),
		.start       (start_nxt),
		.count       (cnt_nxt),
		.low_addr    (low_nxt)
	);

	assign eff_addr_nxt = {addr_nxt[18:2], low_nxt};

	always_ff @(posedge CLOCK) begin
		if (!RST_N || CLK_EN) begin
			state_r    <= state_nxt;
			addr_r     <= addr_nxt;
			start_r    <= start_nxt;
			cnt_r      <= cnt_nxt;
			eff_addr_r <= eff_addr_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Memory array and data path
	// ----------------------------------------------------------------
	// Byte lane b holds data[8b+7:8b] and parity bit b; the array has no
	// reset, so its contents survive reset and sleep alike.
	logic [LANE_W:0] mem [LANES][DEPTH];
	fts_word_t       rd_r;

	always_ff @(posedge CLOCK) begin
		if (CLK_EN && do_write) begin
			for (int b = 0; b < LANES; b++) begin
				if (lane_we[b]) begin
					mem[b][eff_addr_nxt] <= {DQ_IN.parity_io[b],
						DQ_IN.data[b*LANE_W +: LANE_W]};
				end
			end
		end
	end

	// The word is fetched at the capturing edge and shown in the very
	// next cycle; there is no second output stage to hide latency.
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			rd_r <= WORD_RST;
		end else if (CLK_EN) begin
			for (int b = 0; b < LANES; b++) begin
				rd_r.parity_io[b] <= mem[b][eff_addr_nxt][LANE_W];
				rd_r.data[b*LANE_W +: LANE_W] <=
					mem[b][eff_addr_nxt][LANE_W-1:0];
			end
		end
	end

	assign DQ_OUT = rd_r;
	// Drive only in a read data phase; write, idle and sleep all float.
	assign DQ_OE = (state_r == ST_READ) && !oe_n_s && !sleep_s;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	strobe_capture_a: assert property (
		@(posedge CLOCK) disable iff (!RST_N)
		(CLK_EN && !sleep_s && controller_addr_strobe_n_take) |=> addr_r == $past(BUS_REQ.addr))
		else $error("Controller strobe did not capture the address.");

	counter_load_a: assert property (
		@(posedge CLOCK) disable iff (!RST_N)
		(CLK_EN && !sleep_s && (processor_addr_strobe_n_take || controller_addr_strobe_n_take) && sel_now)
		|=> (eff_addr_r == $past(BUS_REQ.addr)) && (cnt_r == CNT_RST))
		else $error("Burst start did not load the low address bits.");

	proc_priority_a: assert property (
		@(posedge CLOCK) disable iff (!RST_N)
		(CLK_EN && !sleep_s && processor_addr_strobe_n_take && sel_now)
		|=> state_r == ST_READ)
		else $error("Controller strobe acted beside the processor strobe.");

	sleep_hold_a: assert property (
		@(posedge CLOCK) disable iff (!RST_N)
		(CLK_EN && sleep_s) |=> !DQ_OE && state_r == ST_IDLE)
		else $error("Device stayed active while asleep.");

	read_flow_a: assert property (
		@(posedge CLOCK) disable iff (!RST_N)
		(state_r == ST_READ) |-> DQ_OUT == {mem[1][eff_addr_r][LANE_W],
			mem[0][eff_addr_r][LANE_W], mem[1][eff_addr_r][LANE_W-1:0],
			mem[0][eff_addr_r][LANE_W-1:0]})
		else $error("Read data does not match the captured address.");

	oe_drive_a: assert property (
		@(posedge CLOCK) disable iff (!RST_N)
		(state_r == ST_READ && !sleep_s) |-> DQ_OE == !oe_n_s)
		else $error("Output enable did not steer the data lines.");

	write_float_a: assert property (
		@(posedge CLOCK) disable iff (!RST_N)
		(state_r != ST_READ) |-> !DQ_OE)
		else $error("Lines driven outside a read data phase.");

	burst_step_a: assert property (
		@(posedge CLOCK) disable iff (!RST_N)
		(CLK_EN && !sleep_s && state_r != ST_IDLE && !processor_addr_strobe_n_take
		&& !controller_addr_strobe_n_take && !BUS_REQ.burst_step_n)
		|=> cnt_r == 2'($past(cnt_r) + CNT_STEP))
		else $error("Step input did not advance the counter.");

	burst_order_a: assert property (
		@(posedge CLOCK) disable iff (!RST_N)
		(state_r != ST_IDLE) |-> eff_addr_r[1:0] == (order_r
			? (start_r ^ cnt_r) : 2'(start_r + cnt_r)))
		else $error("Burst address sequence is wrong.");

	global_write_a: assert property (
		@(posedge CLOCK) disable iff (!RST_N)
		(CLK_EN && !sleep_s && state_r != ST_IDLE && !processor_addr_strobe_n_take
		&& !BUS_REQ.global_write_n && (sel_now || !controller_addr_strobe_n_take))
		|=> state_r == ST_WRITE)
		else $error("Global write did not start a write.");
endmodule

// >>> fts_host_model.sv
// Processor-side bus master model that drives the memory port.
`timescale 1ns/10ps

module fts_host_model (
	input  wire logic               clock,
	input  wire fts_pkg::fts_word_t dq_out,
	input  wire logic               dq_oe,
	output fts_pkg::fts_req_t       bus_req,
	output fts_pkg::fts_word_t      dq_in
);
	import fts_pkg::*;
	logic      drv;
	fts_word_t dat;
	fts_word_t last;

	// Released lines have no keeper, so show the inverse of the last level.
	assign dq_in = dq_oe ? dq_out : (drv ? dat : ~last);

	always @(posedge clock) begin
		last <= dq_in;
	end

	initial begin
		bus_req = '1;
		drv = 1'b0;
		dat = '0;
		last = '0;
	end

	// One request per edge, changed only at the falling edge before it.
	task automatic op(input logic [1:0] st_n, input logic cs_n,
		input logic [18:0] a, input logic gw_n, input logic gate_n,
		input logic [1:0] sel_n, input logic step_n, input fts_word_t d);
		@(negedge clock);
		bus_req.addr = a;
		bus_req.processor_addr_strobe_n = st_n[1];
		bus_req.controller_addr_strobe_n = st_n[0];
		bus_req.chip_select_a_n = cs_n;
		bus_req.chip_select_b = 1'b1;
		bus_req.burst_step_n = step_n;
		bus_req.global_write_n = gw_n;
		bus_req.byte_write_gate_n = gate_n;
		bus_req.byte_lane_select_n = sel_n;
		drv = !(gw_n && gate_n);
		dat = d;
	endtask
endmodule

// >>> fts_sram_port_tb_top.sv
// Self-checking bench for the flow-through memory port.
`timescale 1ns/10ps

`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin \
	error_cnt++; $display("BAD %s exp %h got %h", n, e, s); end end

module fts_sram_port_tb_top;
	import fts_pkg::*;
	localparam logic [18:0] BASE = 19'h00104;
	logic      clock;
	logic      rst_n;
	logic      burst_order;
	logic      sleep_request;
	logic      oe_n;
	fts_req_t  bus_req;
	fts_word_t dq_in;
	fts_word_t dq_out;
	fts_word_t e;
	logic      dq_oe;
	logic      sleeping;
	int        error_cnt = 0;
	int        checked = 0;

	fts_sram_port u_fts_sram_port (.CLOCK(clock), .RST_N(rst_n),
		.CLK_EN(1'b1), .BUS_REQ(bus_req), .BURST_ORDER(burst_order),
		.SLEEP_REQUEST(sleep_request), .OUTPUT_ENABLE_N(oe_n),
		.DQ_IN(dq_in), .DQ_OUT(dq_out), .DQ_OE(dq_oe), .SLEEPING(sleeping));

	fts_host_model u_fts_host_model (.clock(clock), .dq_out(dq_out),
		.dq_oe(dq_oe), .bus_req(bus_req), .dq_in(dq_in));

	function automatic fts_word_t pat(input logic [18:0] a);
		return {a[1:0], 8'ha0 ^ a[7:0], 8'h5c ^ a[7:0]};
	endfunction

	task automatic rd(input logic [18:0] a);
		u_fts_host_model.op(2'b01, 1'b0, a, 1'b1, 1'b1, 2'h3, 1'b1, '0);
	endtask

	task automatic wr(input logic [18:0] a, input logic gw_n,
		input logic gate_n, input logic [1:0] sel_n, input fts_word_t d);
		u_fts_host_model.op(2'b10, 1'b0, a, gw_n, gate_n, sel_n, 1'b1, d);
	endtask

	task automatic nop(input logic step_n, input int n);
		repeat (n) u_fts_host_model.op(2'b11, 1'b0, BASE, 1'b1, 1'b1, 2'h3,
			step_n, '0);
	endtask

	task automatic reset(input logic order);
		rst_n = 1'b0;
		burst_order = order;
		// Three edges so the strap clears its synchroniser.
		repeat (3) @(posedge clock);
		@(negedge clock);
		`CHK("reset oe", 1'b0, dq_oe)
		`CHK("reset data", 18'h00000, dq_out)
		rst_n = 1'b1;
	endtask

	task automatic burst(input logic order);
		logic [1:0] lo;
		reset(order);
		rd(BASE + 19'h1);
		for (int k = 0; k < 4; k++) begin
			lo = order ? 2'h1 ^ 2'(k) : 2'h1 + 2'(k);
			nop(1'b0, 1);
			`CHK("burst", pat({BASE[18:2], lo}), dq_out)
		end
		$display("test burst order %0d done", order);
	endtask

	task automatic complete_run;
		$display("checks %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	initial begin
		rst_n = 1'b0;
		burst_order = 1'b1;
		sleep_request = 1'b0;
		oe_n = 1'b0;
		reset(1'b1);
		for (int i = 0; i < 4; i++)
			wr(BASE + 19'(i), 1'b0, 1'b1, 2'h3, pat(BASE + 19'(i)));
		nop(1'b1, 1);
		`CHK("write float", 1'b0, dq_oe)
		for (int i = 0; i < 4; i++) begin
			rd(BASE + 19'(i));
			nop(1'b1, 1);
			`CHK("read data", pat(BASE + 19'(i)), dq_out)
			`CHK("read drive", 1'b1, dq_oe)
		end
		$display("test write read done");
		burst(1'b1);
		burst(1'b0);
		// Deselect first so the lines are free for the host to drive.
		u_fts_host_model.op(2'b10, 1'b1, BASE, 1'b1, 1'b1, 2'h3, 1'b1, '0);
		u_fts_host_model.op(2'b00, 1'b0, BASE, 1'b0, 1'b1, 2'h3, 1'b1,
			~pat(BASE));
		nop(1'b1, 1);
		`CHK("strobe clash", pat(BASE), dq_out)
		`CHK("clash drive", 1'b1, dq_oe)
		u_fts_host_model.op(2'b10, 1'b1, BASE, 1'b1, 1'b1, 2'h3, 1'b1, '0);
		wr(BASE + 19'h2, 1'b1, 1'b0, 2'h2, 18'h1ffff);
		rd(BASE + 19'h2);
		nop(1'b1, 1);
		e = pat(BASE + 19'h2);
		e.data[7:0] = 8'hff;
		e.parity_io[0] = 1'b1;
		`CHK("lane write", e, dq_out)
		$display("test strobes and lanes done");
		oe_n = 1'b1;
		nop(1'b1, 4);
		rd(BASE);
		nop(1'b1, 1);
		`CHK("oe float", 1'b0, dq_oe)
		oe_n = 1'b0;
		u_fts_host_model.op(2'b10, 1'b1, BASE, 1'b1, 1'b1, 2'h3, 1'b1, '0);
		nop(1'b1, 1);
		`CHK("deselect", 1'b0, dq_oe)
		sleep_request = 1'b1;
		nop(1'b1, 4);
		`CHK("sleeping", 1'b1, sleeping)
		rd(BASE);
		nop(1'b1, 1);
		`CHK("sleep float", 1'b0, dq_oe)
		sleep_request = 1'b0;
		nop(1'b1, 4);
		rd(BASE);
		nop(1'b1, 1);
		`CHK("kept data", pat(BASE), dq_out)
		$display("test output control done");
		complete_run();
	end
endmodule
